//--- design/hpmux_pkg.sv
// What this block does
// R1 - dack0 pin: field A[5:4] 00 dma ack, 01 gpio1_line6, 10 kbc port1 line5
// R2 - drq0 pin: field A[7:6] 00 dma request, 01 gpio1_line7, 10 kbc line4, 11 sci
// R3 - irq14 pin: field A[1:0] 00 irq14, 01 gpio1_line4, 10 power led
// R4 - irq15 pin: field A[3:2] 00 irq15, 01 gpio1_line5, 10 watchdog
// R5 - gpio1_line4 alternates: address-decode chip select or kbc port1 line7
// R6 - gpio1_line5 alternates: address-decode write enable or kbc port1 line2
// R7 - gpio1_line6 may carry the watchdog output instead of plain gpio
// R8 - gpio1_line7 may carry the power led output instead of plain gpio
// R9 - clock config bit 5 picks a 24 or 48 MHz input clock
// R10 - smi pin: field B[4:3] 00 smi, 01 gpio2_line1, 10 kbc port1 line6
// R11 - power events drive smi low, or raise sci instead in acpi mode
// R12 - field B[5]: 0 panel switch output, 1 gpio2_line2 (alternate kbc line4)
// R13 - field B[7:6]: 00 panel switch input, 01 gpio2_line3 (alternate kbc line5)
// R14 - field C[5:4]: 01 gpio2_line4 (alternate kbc line6), 10 kbc port1 line3
// R15 - gpio2_line1 may carry kbc port1 line3 as alternate
// R16 - gpio2_line0 may carry keyboard reset from kbc port2 line0
// R17 - gpio2_line5 may carry address-20 gate from kbc port2 line1
// R18 - host asserts terminal count; device ends the current dma transfer on it
// R19 - dma channels 1 to 3 have fixed request and acknowledge pins
// R20 - master reset returns every select field to its default encoding
package hpmux_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_FIELD_A = 8'h00;
  localparam logic [7:0] OFS_FIELD_B = 8'h04;
  localparam logic [7:0] OFS_FIELD_C = 8'h08;
  localparam logic [7:0] OFS_CLKCFG = 8'h0c;
  localparam logic [7:0] OFS_ALT = 8'h10;
  localparam logic [7:0] OFS_GP_OUT = 8'h14;
  localparam logic [7:0] OFS_GP_DIR = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_GP_IN = 8'h24;
  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0] RST_FIELD = 8'h00;
  localparam logic [11:0] RST_ALT = 12'h000;
  localparam logic [9:0] RST_GP = 10'h000;
  localparam int CLK48_BIT = 5;
  localparam int ACPI_BIT = 0;
  localparam int ST_TC_BIT = 0;
  localparam int ST_PM_BIT = 1;
  // ****************************************
  // pad and gpio line indices
  // ****************************************
  localparam int NPAD = 10;
  localparam int P_DACK0 = 0;
  localparam int P_DRQ0 = 1;
  localparam int P_IRQ14 = 2;
  localparam int P_IRQ15 = 3;
  localparam int P_SMI = 4;
  localparam int P_PSWO = 5;
  localparam int P_PSWI = 6;
  localparam int P_GPIO2_LINE4 = 7;
  localparam int P_GPIO2_LINE0 = 8;
  localparam int P_GPIO2_LINE5 = 9;
  // gpio slots: 0..3 gpio1 lines 4..7, 4..9 gpio2 lines 0..5
  localparam int G14 = 0;
  localparam int G15 = 1;
  localparam int G16 = 2;
  localparam int G17 = 3;
  localparam int G20 = 4;
  localparam int G21 = 5;
  localparam int G22 = 6;
  localparam int G23 = 7;
  localparam int G24 = 8;
  localparam int G25 = 9;
  // two-bit select encodings
  localparam logic [1:0] SEL_DEF = 2'h0;
  localparam logic [1:0] SEL_GP = 2'h1;
  localparam logic [1:0] SEL_ALT = 2'h2;
  localparam logic [1:0] SEL_X = 2'h3;
endpackage

//--- design/hpmux_top.sv
`timescale 1ns/100ps
module hpmux_top (
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared pads: input, output, output enable (low drives)
  input wire logic [hpmux_pkg::NPAD-1:0] pad_i,
  output logic [hpmux_pkg::NPAD-1:0] pad_o,
  output logic [hpmux_pkg::NPAD-1:0] pad_oe_n,
  // dma channels 1..3, fixed pins
  input wire logic [2:0] dma_req_core,
  output logic [2:0] dma_req_pin,
  input wire logic [2:0] dma_ack_n_pin,
  output logic [2:0] dma_ack_n_core,
  input wire logic dma0_req_core,
  output logic dma0_ack_n_core,
  input wire logic tc_pin,
  output logic dma_end,
  // function sources and sinks inside the device
  input wire logic irq14_core,
  input wire logic irq15_core,
  input wire logic watchdog_output,
  input wire logic power_led_output,
  input wire logic addr_decode_chip_select,
  input wire logic addr_decode_write_enable,
  input wire logic panel_switch_output,
  output logic panel_switch_input,
  input wire logic pm_event,
  input wire logic [7:0] kbc_port1_out,
  input wire logic [7:0] kbc_port1_dir,
  output logic [7:0] kbc_port1_in,
  input wire logic [1:0] kbc_port2_out,
  output logic clk48_sel
);
  import hpmux_pkg::*;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] fa_q, fb_q, fc_q, clk_q;
  logic [11:0] alt_q;
  logic [9:0] gpo_q, gpd_q, gpi_q;
  logic acpi_q, tc_q, pm_q;
  logic wr_en, setup;
  logic [31:0] rd_d;
  logic dec_ok;

  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;
  // zero wait states: the access phase always completes in one cycle
  assign pready = 1'b1;

  // select fields fall back to defaults so legacy functions come up first
  always_ff @(posedge mclk) begin
    if (srst) begin
      fa_q <= RST_FIELD; // R20
      fb_q <= RST_FIELD; // R20
      fc_q <= RST_FIELD; // R20
      clk_q <= RST_FIELD;
      alt_q <= RST_ALT;
      gpo_q <= RST_GP;
      gpd_q <= RST_GP;
      acpi_q <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        OFS_FIELD_A: fa_q <= pwdata[7:0];
        OFS_FIELD_B: fb_q <= pwdata[7:0];
        OFS_FIELD_C: fc_q <= pwdata[7:0];
        OFS_CLKCFG: clk_q <= pwdata[7:0];
        OFS_ALT: alt_q <= pwdata[11:0];
        OFS_GP_OUT: gpo_q <= pwdata[9:0];
        OFS_GP_DIR: gpd_q <= pwdata[9:0];
        OFS_CTRL: acpi_q <= pwdata[ACPI_BIT];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      tc_q <= 1'b0;
      pm_q <= 1'b0;
    end else begin
      tc_q <= tc_pin | (tc_q & ~(wr_en && paddr == OFS_STATUS && pwdata[ST_TC_BIT])); // R18
      pm_q <= pm_event | (pm_q & ~(wr_en && paddr == OFS_STATUS && pwdata[ST_PM_BIT])); // R11
    end
  end

  // read mux, sampled in the setup phase so prdata is a flop in the access phase
  always_comb begin
    rd_d = 32'h0;
    dec_ok = 1'b1;
    case (paddr)
      OFS_FIELD_A: rd_d[7:0] = fa_q;
      OFS_FIELD_B: rd_d[7:0] = fb_q;
      OFS_FIELD_C: rd_d[7:0] = fc_q;
      OFS_CLKCFG: rd_d[7:0] = clk_q;
      OFS_ALT: rd_d[11:0] = alt_q;
      OFS_GP_OUT: rd_d[9:0] = gpo_q;
      OFS_GP_DIR: rd_d[9:0] = gpd_q;
      OFS_CTRL: rd_d[ACPI_BIT] = acpi_q;
      OFS_STATUS: rd_d[1:0] = {pm_q, tc_q};
      OFS_GP_IN: rd_d[9:0] = gpi_q;
      default: dec_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_d;
      pslverr <= ~dec_ok;
    end
  end

  // ****************************************
  // gpio slots with alternate functions
  // ****************************************
  // returns {drive, value}: alternate source when picked, else plain gpio
  function automatic logic [1:0] gp_slot(input logic use_alt, input logic a_drv, input logic a_val,
                                         input logic g_drv, input logic g_val);
    gp_slot = use_alt ? {a_drv, a_val} : {g_drv, g_val};
  endfunction

  logic [9:0] gdrv, gval;
  always_comb begin
    {gdrv[G14], gval[G14]} = gp_slot(alt_q[1:0] != SEL_DEF,
      alt_q[1:0] == SEL_GP ? 1'b1 : kbc_port1_dir[7],
      alt_q[1:0] == SEL_GP ? addr_decode_chip_select : kbc_port1_out[7], gpd_q[G14], gpo_q[G14]); // R5
    {gdrv[G15], gval[G15]} = gp_slot(alt_q[3:2] != SEL_DEF,
      alt_q[3:2] == SEL_GP ? 1'b1 : kbc_port1_dir[2],
      alt_q[3:2] == SEL_GP ? addr_decode_write_enable : kbc_port1_out[2], gpd_q[G15], gpo_q[G15]); // R6
    {gdrv[G16], gval[G16]} = gp_slot(alt_q[4], 1'b1, watchdog_output, gpd_q[G16], gpo_q[G16]); // R7
    {gdrv[G17], gval[G17]} = gp_slot(alt_q[5], 1'b1, power_led_output, gpd_q[G17], gpo_q[G17]); // R8
    {gdrv[G20], gval[G20]} = gp_slot(alt_q[6], 1'b1, kbc_port2_out[0], gpd_q[G20], gpo_q[G20]); // R16
    {gdrv[G21], gval[G21]} = gp_slot(alt_q[7], kbc_port1_dir[3], kbc_port1_out[3],
      gpd_q[G21], gpo_q[G21]); // R15
    {gdrv[G22], gval[G22]} = gp_slot(alt_q[8], kbc_port1_dir[4], kbc_port1_out[4],
      gpd_q[G22], gpo_q[G22]); // R12
    {gdrv[G23], gval[G23]} = gp_slot(alt_q[9], kbc_port1_dir[5], kbc_port1_out[5],
      gpd_q[G23], gpo_q[G23]); // R13
    {gdrv[G24], gval[G24]} = gp_slot(alt_q[10], kbc_port1_dir[6], kbc_port1_out[6],
      gpd_q[G24], gpo_q[G24]); // R14
    {gdrv[G25], gval[G25]} = gp_slot(alt_q[11], 1'b1, kbc_port2_out[1], gpd_q[G25], gpo_q[G25]); // R17
  end

  // ****************************************
  // pad function selection
  // ****************************************
  logic smi_n, sci;
  logic [NPAD-1:0] drv_d, val_d;
  // one event source, two reporting styles chosen by acpi mode
  assign smi_n = ~(pm_q & ~acpi_q); // R11
  assign sci = pm_q & acpi_q; // R11

  // code 11 on a two-bit field with no function leaves the pad as an input
  always_comb begin
    drv_d = '0;
    val_d = '0;
    case (fa_q[5:4])
      SEL_GP: {drv_d[P_DACK0], val_d[P_DACK0]} = {gdrv[G16], gval[G16]}; // R1
      SEL_ALT: {drv_d[P_DACK0], val_d[P_DACK0]} = {kbc_port1_dir[5], kbc_port1_out[5]}; // R1
      default: ;
    endcase
    case (fa_q[7:6])
      SEL_DEF: {drv_d[P_DRQ0], val_d[P_DRQ0]} = {1'b1, dma0_req_core}; // R2
      SEL_GP: {drv_d[P_DRQ0], val_d[P_DRQ0]} = {gdrv[G17], gval[G17]}; // R2
      SEL_ALT: {drv_d[P_DRQ0], val_d[P_DRQ0]} = {kbc_port1_dir[4], kbc_port1_out[4]}; // R2
      default: {drv_d[P_DRQ0], val_d[P_DRQ0]} = {1'b1, sci}; // R2
    endcase
    case (fa_q[1:0])
      SEL_DEF: {drv_d[P_IRQ14], val_d[P_IRQ14]} = {1'b1, irq14_core}; // R3
      SEL_GP: {drv_d[P_IRQ14], val_d[P_IRQ14]} = {gdrv[G14], gval[G14]}; // R3
      SEL_ALT: {drv_d[P_IRQ14], val_d[P_IRQ14]} = {1'b1, power_led_output}; // R3
      default: ;
    endcase
    case (fa_q[3:2])
      SEL_DEF: {drv_d[P_IRQ15], val_d[P_IRQ15]} = {1'b1, irq15_core}; // R4
      SEL_GP: {drv_d[P_IRQ15], val_d[P_IRQ15]} = {gdrv[G15], gval[G15]}; // R4
      SEL_ALT: {drv_d[P_IRQ15], val_d[P_IRQ15]} = {1'b1, watchdog_output}; // R4
      default: ;
    endcase
    case (fb_q[4:3])
      SEL_DEF: {drv_d[P_SMI], val_d[P_SMI]} = {1'b1, smi_n}; // R10
      SEL_GP: {drv_d[P_SMI], val_d[P_SMI]} = {gdrv[G21], gval[G21]}; // R10
      SEL_ALT: {drv_d[P_SMI], val_d[P_SMI]} = {kbc_port1_dir[6], kbc_port1_out[6]}; // R10
      default: ;
    endcase
    {drv_d[P_PSWO], val_d[P_PSWO]} = fb_q[5] ? {gdrv[G22], gval[G22]} : {1'b1, panel_switch_output}; // R12
    if (fb_q[7:6] == SEL_GP) begin
      {drv_d[P_PSWI], val_d[P_PSWI]} = {gdrv[G23], gval[G23]}; // R13
    end
    case (fc_q[5:4])
      SEL_GP: {drv_d[P_GPIO2_LINE4], val_d[P_GPIO2_LINE4]} = {gdrv[G24], gval[G24]}; // R14
      SEL_ALT: {drv_d[P_GPIO2_LINE4], val_d[P_GPIO2_LINE4]} = {kbc_port1_dir[3], kbc_port1_out[3]}; // R14
      default: ;
    endcase
    {drv_d[P_GPIO2_LINE0], val_d[P_GPIO2_LINE0]} = {gdrv[G20], gval[G20]}; // R16
    {drv_d[P_GPIO2_LINE5], val_d[P_GPIO2_LINE5]} = {gdrv[G25], gval[G25]}; // R17
  end

  // kbc lines read back as a wired-and of every pad carrying them, except gpio1 lines 4 and 5 under alternate code 11
  logic [7:0] kin_d;
  always_comb begin
    kin_d = 8'hff;
    if (fa_q[5:4] == SEL_ALT) kin_d[5] = kin_d[5] & pad_i[P_DACK0];
    if (fa_q[7:6] == SEL_ALT) kin_d[4] = kin_d[4] & pad_i[P_DRQ0];
    if (fa_q[1:0] == SEL_GP && alt_q[1:0] == SEL_ALT) kin_d[7] = kin_d[7] & pad_i[P_IRQ14];
    if (fa_q[3:2] == SEL_GP && alt_q[3:2] == SEL_ALT) kin_d[2] = kin_d[2] & pad_i[P_IRQ15];
    if (fb_q[4:3] == SEL_ALT) kin_d[6] = kin_d[6] & pad_i[P_SMI];
    if (fb_q[4:3] == SEL_GP && alt_q[7]) kin_d[3] = kin_d[3] & pad_i[P_SMI];
    if (fb_q[5] && alt_q[8]) kin_d[4] = kin_d[4] & pad_i[P_PSWO];
    if (fb_q[7:6] == SEL_GP && alt_q[9]) kin_d[5] = kin_d[5] & pad_i[P_PSWI];
    if (fc_q[5:4] == SEL_GP && alt_q[10]) kin_d[6] = kin_d[6] & pad_i[P_GPIO2_LINE4];
    if (fc_q[5:4] == SEL_ALT) kin_d[3] = kin_d[3] & pad_i[P_GPIO2_LINE4];
  end

  // ****************************************
  // pad and core-facing flops
  // ****************************************
  // every data output is registered; one cycle from source to pad
  always_ff @(posedge mclk) begin
    if (srst) begin
      pad_o <= '0;
      pad_oe_n <= '1;
      kbc_port1_in <= 8'hff;
      gpi_q <= RST_GP;
      dma0_ack_n_core <= 1'b1;
      panel_switch_input <= 1'b1;
    end else begin
      pad_o <= val_d;
      pad_oe_n <= ~drv_d;
      kbc_port1_in <= kin_d;
      gpi_q <= {pad_i[P_GPIO2_LINE5], pad_i[P_GPIO2_LINE4], pad_i[P_PSWI], pad_i[P_PSWO], pad_i[P_SMI],
                pad_i[P_GPIO2_LINE0], pad_i[P_DRQ0], pad_i[P_DACK0], pad_i[P_IRQ15], pad_i[P_IRQ14]};
      dma0_ack_n_core <= (fa_q[5:4] == SEL_DEF) ? pad_i[P_DACK0] : 1'b1; // R1
      panel_switch_input <= (fb_q[7:6] == SEL_DEF) ? pad_i[P_PSWI] : 1'b1; // R13
    end
  end

  // fixed dma channels, terminal count and clock choice
  always_ff @(posedge mclk) begin
    if (srst) begin
      dma_req_pin <= 3'h0;
      dma_ack_n_core <= 3'h7;
      dma_end <= 1'b0;
      clk48_sel <= 1'b0;
    end else begin
      dma_req_pin <= dma_req_core; // R19
      dma_ack_n_core <= dma_ack_n_pin; // R19
      dma_end <= tc_pin; // R18
      clk48_sel <= clk_q[CLK48_BIT]; // R9
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence drq0_dma_s;
    fa_q[7:6] == SEL_DEF && !srst;
  endsequence
  sequence pm_legacy_s;
    fb_q[4:3] == SEL_DEF && pm_q && !acpi_q && !srst;
  endsequence

  dack0_routing_a: assert property (@(posedge mclk) disable iff (srst) // R1
    fa_q[5:4] == SEL_DEF |=> pad_oe_n[P_DACK0] && dma0_ack_n_core == $past(pad_i[P_DACK0]))
    else $error("dack0 pad not routed to dma ack");
  drq0_request_a: assert property (@(posedge mclk) disable iff (srst) // R2
    drq0_dma_s |=> !pad_oe_n[P_DRQ0] && pad_o[P_DRQ0] == $past(dma0_req_core))
    else $error("drq0 pad does not follow dma request");
  irq14_led_a: assert property (@(posedge mclk) disable iff (srst) // R3
    fa_q[1:0] == SEL_ALT |=> !pad_oe_n[P_IRQ14] && pad_o[P_IRQ14] == $past(power_led_output))
    else $error("irq14 pad does not carry power led");
  irq15_wdt_a: assert property (@(posedge mclk) disable iff (srst) // R4
    fa_q[3:2] == SEL_ALT |=> !pad_oe_n[P_IRQ15] && pad_o[P_IRQ15] == $past(watchdog_output))
    else $error("irq15 pad does not carry watchdog");
  smi_low_a: assert property (@(posedge mclk) disable iff (srst) // R10
    pm_legacy_s |=> !pad_oe_n[P_SMI] && !pad_o[P_SMI])
    else $error("smi not driven low on power event");
  sci_acpi_a: assert property (@(posedge mclk) disable iff (srst) // R11
    fa_q[7:6] == SEL_X && pm_q && acpi_q |=> pad_o[P_DRQ0] ##1 pad_o[P_SMI] || pad_oe_n[P_SMI] || fb_q[4:3] != SEL_DEF)
    else $error("sci or smi wrong in acpi mode");
  tc_end_a: assert property (@(posedge mclk) disable iff (srst) // R18
    tc_pin |=> dma_end && tc_q)
    else $error("terminal count not taken");
  clk_sel_a: assert property (@(posedge mclk) disable iff (srst) // R9
    ##1 clk48_sel == $past(clk_q[CLK48_BIT]))
    else $error("clock select does not follow config bit");
  reset_defaults_a: assert property (@(posedge mclk) // R20
    srst |=> fa_q == RST_FIELD && fb_q == RST_FIELD && fc_q == RST_FIELD && pad_oe_n == '1)
    else $error("select fields not defaulted by reset");
  dma_fixed_a: assert property (@(posedge mclk) disable iff (srst) // R19
    ##1 dma_req_pin == $past(dma_req_core) && dma_ack_n_core == $past(dma_ack_n_pin))
    else $error("fixed dma channel not passed through");
endmodule

//--- testbench/hpmux_host_model.sv
`timescale 1ns/100ps
// ****************************************
// isa host side: dma controller granting requests
// ****************************************
module hpmux_host_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [3:0] req,
  output logic [3:0] ack_n,
  output logic tc
);
  logic busy_q;
  logic [1:0] ch_q;
  logic [3:0] cnt_q;
  logic [3:0] lat;
  // slow mode stretches the grant so the device cannot count on a fixed latency
  assign lat = slow ? 4'h5 : 4'h1;
  // one channel at a time, lowest channel wins; ack held until the request drops
  always_ff @(posedge mclk) begin
    if (srst) begin
      {busy_q, ch_q, cnt_q, tc} <= 8'h00;
      ack_n <= 4'hf;
    end else if (!busy_q) begin
      ack_n <= 4'hf;
      tc <= 1'b0;
      cnt_q <= 4'h0;
      busy_q <= |req;
      for (int i = 3; i >= 0; i--) begin
        if (req[i]) begin
          ch_q <= 2'(i);
        end
      end
    end else begin
      if (cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (cnt_q == lat) begin
        ack_n[ch_q] <= 1'b0;
      end
      tc <= (cnt_q == lat + 4'h2);
      if (!req[ch_q] && cnt_q > lat + 4'h3) begin
        ack_n <= 4'hf;
        busy_q <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/hpmux_top_test.sv
`timescale 1ns/100ps
module hpmux_top_test;
  import hpmux_pkg::*;
  // gpio pattern chosen so each slot but gpio1 lines 4 and 5 differs from the function it replaces
  localparam logic [9:0] GPV = 10'h199;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, tc, dma_end, slow, pswi, clk48, pm, rerr;
  logic irq14, irq15, wdt, led, cs, we, pswo;
  logic [7:0] paddr, kout, kdir, kin;
  logic [31:0] pwdata, prdata, rdat;
  logic [9:0] pad_i, pad_o, pad_oe_n, ext_q;
  logic [3:0] req_all, h_ack;
  wire [3:0] ack_all;
  logic [2:0] dreq_pin;
  logic [1:0] kbc2;
  int n_errors = 0;
  int check_count = 0;
  // ****************************************
  // design, host model and pad wires
  // ****************************************
  hpmux_top uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_n(pad_oe_n), .dma_req_core(req_all[3:1]), .dma_req_pin(dreq_pin), .dma_ack_n_pin(h_ack[3:1]),
    .dma_ack_n_core(ack_all[3:1]), .dma0_req_core(req_all[0]), .dma0_ack_n_core(ack_all[0]), .tc_pin(tc),
    .dma_end(dma_end), .irq14_core(irq14), .irq15_core(irq15), .watchdog_output(wdt), .power_led_output(led),
    .addr_decode_chip_select(cs), .addr_decode_write_enable(we), .panel_switch_output(pswo),
    .panel_switch_input(pswi), .pm_event(pm), .kbc_port1_out(kout), .kbc_port1_dir(kdir), .kbc_port1_in(kin),
    .kbc_port2_out(kbc2), .clk48_sel(clk48));
  hpmux_host_model host (.mclk(mclk), .srst(srst), .slow(slow),
    .req({dreq_pin, ~pad_oe_n[P_DRQ0] & pad_o[P_DRQ0]}), .ack_n(h_ack), .tc(tc));
  // a released pad shows what the outside drives; dack0 is wired-and with the host grant
  assign pad_i = (pad_oe_n & ext_q & {9'h1ff, h_ack[0]}) | (~pad_oe_n & pad_o);
  // clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // pads lag register writes by a pipeline stage, three edges leave margin
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic pad(input int i, input logic v);
    chk("pad_oe_n", 32'(pad_oe_n[i]), 32'h0);
    chk("pad_o", 32'(pad_o[i]), 32'(v));
  endtask
  task automatic pm_pulse;
    pm <= 1'b1;
    @(posedge mclk);
    pm <= 1'b0;
    settle;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {srst, psel, penable, pwrite, slow, pm} = 6'b100000;
    {paddr, pwdata, req_all} = '0;
    ext_q = 10'h3bf;
    {irq14, irq15, wdt, led, cs, we, pswo} = 7'b1010011;
    {kout, kdir, kbc2} = 18'h3fc02;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("select reset", rdat, 32'h0);
    end
    settle;
    chk("clk48 reset", 32'(clk48), 32'h0);
    pad(P_IRQ14, 1'b1);
    pad(P_IRQ15, 1'b0);
    pad(P_PSWO, 1'b1);
    pad(P_SMI, 1'b1);
    pad(P_DRQ0, 1'b0);
    chk("dack0 released", 32'(pad_oe_n[P_DACK0]), 32'h1);
    chk("field c off", 32'(pad_oe_n[P_GPIO2_LINE4]), 32'h1);
    chk("panel in", 32'(pswi), 32'h0);
    // dma on every channel, alternating prompt and slow grants
    for (int c = 0; c < 4; c++) begin
      slow <= c[0];
      req_all[c] <= 1'b1;
      for (int n = 0; n < 40 && ack_all[c] !== 1'b0; n++) @(posedge mclk);
      chk("ack to core", 32'(ack_all[c]), 32'h0);
      if (c > 0) chk("req pin", 32'(dreq_pin[c-1]), 32'h1);
      for (int n = 0; n < 40 && dma_end !== 1'b1; n++) @(posedge mclk);
      chk("dma end", 32'(dma_end), 32'h1);
      req_all[c] <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("tc status", 32'(rdat[ST_TC_BIT]), 32'h1);
      apb(1'b1, OFS_STATUS, 32'h1);
      settle;
    end
    // gpio selections on field a, then their alternates
    apb(1'b1, OFS_GP_DIR, 32'h3ff);
    apb(1'b1, OFS_GP_OUT, 32'(GPV));
    apb(1'b1, OFS_FIELD_A, 32'h55);
    settle;
    pad(P_DACK0, GPV[G16]);
    pad(P_DRQ0, GPV[G17]);
    pad(P_IRQ14, GPV[G14]);
    pad(P_IRQ15, GPV[G15]);
    apb(1'b1, OFS_ALT, 32'h35);
    settle;
    pad(P_IRQ14, cs);
    pad(P_IRQ15, we);
    pad(P_DACK0, wdt);
    pad(P_DRQ0, led);
    apb(1'b1, OFS_FIELD_A, 32'haa);
    ext_q <= 10'h000;
    settle;
    pad(P_IRQ14, led);
    pad(P_IRQ15, wdt);
    chk("kbc line5", 32'(kin[5]), 32'h0);
    chk("kbc line4", 32'(kin[4]), 32'h0);
    // gpio1 lines 4 and 5 on their keyboard-controller alternates, pads left to the outside
    apb(1'b1, OFS_FIELD_A, 32'h05);
    apb(1'b1, OFS_ALT, 32'h0a);
    settle;
    chk("kbc line7", 32'(kin[7]), 32'h0);
    chk("kbc line2", 32'(kin[2]), 32'h0);
    chk("irq14 kbc released", 32'(pad_oe_n[P_IRQ14]), 32'h1);
    // power events: sci in acpi mode, smi otherwise
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_FIELD_A, 32'hc0);
    pm_pulse;
    pad(P_DRQ0, 1'b1);
    pad(P_SMI, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h2);
    settle;
    pad(P_DRQ0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0);
    pm_pulse;
    pad(P_SMI, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("pm status", 32'(rdat[ST_PM_BIT]), 32'h1);
    apb(1'b1, OFS_STATUS, 32'h2);
    // field b and c gpio selections, then their alternates
    apb(1'b1, OFS_FIELD_B, 32'h68);
    apb(1'b1, OFS_FIELD_C, 32'h10);
    apb(1'b1, OFS_ALT, 32'h0);
    settle;
    pad(P_SMI, GPV[G21]);
    pad(P_PSWO, GPV[G22]);
    chk("panel in off", 32'(pswi), 32'h1);
    pad(P_PSWI, GPV[G23]);
    pad(P_GPIO2_LINE4, GPV[G24]);
    pad(P_GPIO2_LINE0, GPV[G20]);
    pad(P_GPIO2_LINE5, GPV[G25]);
    apb(1'b1, OFS_ALT, 32'h840);
    settle;
    pad(P_GPIO2_LINE0, kbc2[0]);
    pad(P_GPIO2_LINE5, kbc2[1]);
    chk("kbc idle", 32'(kin), 32'hff);
    apb(1'b1, OFS_ALT, 32'h80);
    settle;
    chk("kbc line3 alt", 32'(kin[3]), 32'h0);
    apb(1'b1, OFS_FIELD_B, 32'h10);
    apb(1'b1, OFS_FIELD_C, 32'h20);
    apb(1'b1, OFS_ALT, 32'h0);
    settle;
    chk("kbc line6", 32'(kin[6]), 32'h0);
    chk("kbc line3", 32'(kin[3]), 32'h0);
    // input clock choice and an unmapped offset
    apb(1'b1, OFS_CLKCFG, 32'h20);
    settle;
    chk("clk48", 32'(clk48), 32'h1);
    apb(1'b0, OFS_CLKCFG, 32'h0);
    chk("clkcfg read", rdat, 32'h20);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    print_verdict;
  end
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
endmodule
